// File: core/rms_pkg.sv
/*
 * rms_pkg: shared constants of the reference monitor status register bank:
 * byte offsets, field positions, writable-bit masks, reset values and the
 * reset-sequence timing.
 * assumes: an 8-bit register port with a 7-bit address and a 100 MHz mclk.
 */
package rms_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // widths
    localparam int ADDR_W     = 7;   // register address width
    localparam int DATA_W     = 8;   // register data width
    localparam int MULT_W     = 14;  // profile multiplier N width
    localparam int LIM_W      = 16;  // frequency-check limit width
    localparam int CHK_W      = 9;   // monitoring cycles, stored value plus one
    localparam int LOOP_EVT_W = 3;   // lock, lost lock, hold

    ////////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [6:0] OFF_IDENT      = 7'h00;  // identity_and_reset_done
    localparam logic [6:0] OFF_REF_FAIL   = 7'h02;  // input_failure_event
    localparam logic [6:0] OFF_LOOP_EVT   = 7'h03;  // loop_event_status
    localparam logic [6:0] OFF_REF_MASK   = 7'h09;  // input failure interrupt mask
    localparam logic [6:0] OFF_LOOP_MASK  = 7'h0A;  // loop event interrupt mask
    localparam logic [6:0] OFF_A_MULT_LO  = 7'h67;  // profile_a_multiplier_lo
    localparam logic [6:0] OFF_A_MULT_HI  = 7'h68;  // profile_a multiplier high bits
    localparam logic [6:0] OFF_A_CYC_LOW  = 7'h69;  // profile_a cycle lower limit
    localparam logic [6:0] OFF_A_CYC_HIGH = 7'h6A;  // profile_a_cycle_upper_limit
    localparam logic [6:0] OFF_A_FLO_LO   = 7'h6B;  // profile_a_freq_lower_lo
    localparam logic [6:0] OFF_A_FLO_HI   = 7'h6C;  // profile_a_freq_lower_hi
    localparam logic [6:0] OFF_A_FHI_LO   = 7'h6D;  // profile_a_freq_upper_lo
    localparam logic [6:0] OFF_A_FHI_HI   = 7'h6E;  // profile_a_freq_upper_hi
    localparam logic [6:0] OFF_A_CHECK    = 7'h6F;  // profile_a_check_cycles
    localparam logic [6:0] OFF_A_QSEL     = 7'h70;  // profile_a_quarter_select
    localparam logic [6:0] OFF_B_MULT_LO  = 7'h71;  // profile_b_multiplier_lo
    localparam logic [6:0] OFF_B_MULT_HI  = 7'h72;  // profile_b_multiplier_hi
    localparam logic [6:0] OFF_B_CYC_LOW  = 7'h73;  // profile_b_cycle_lower_limit
    localparam logic [6:0] OFF_B_CYC_HIGH = 7'h74;  // profile_b_cycle_upper_limit
    localparam logic [6:0] OFF_B_FLO_LO   = 7'h75;  // profile_b_freq_lower_lo
    localparam logic [6:0] OFF_B_FLO_HI   = 7'h76;  // profile_b_freq_lower_hi
    localparam logic [6:0] OFF_B_FHI_LO   = 7'h77;  // profile_b_freq_upper_lo
    localparam logic [6:0] OFF_B_FHI_HI   = 7'h78;  // profile_b_freq_upper_hi
    localparam logic [6:0] OFF_B_CHECK    = 7'h79;  // profile_b_check_cycles
    localparam logic [6:0] OFF_B_QSEL     = 7'h7A;  // profile_b_quarter_select
    localparam logic [6:0] OFF_PRESCALE   = 7'h7E;  // input_prescaler_control
    localparam logic [6:0] CFG_FIRST      = 7'h67;  // first byte of config storage
    localparam logic [6:0] CFG_LAST       = 7'h7E;  // last byte of config storage

    ////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int LOCK_BIT     = 0;  // loop achieved lock
    localparam int LOST_BIT     = 1;  // loop lost lock
    localparam int HOLD_BIT     = 2;  // loop entered hold
    localparam int REF_FAIL_BIT = 0;  // reference judged failed
    localparam int READY_BIT    = 7;  // reset sequence finished
    localparam int IDENT_LSB    = 0;  // part_ident_field low bit
    localparam int IDENT_MSB    = 4;  // part_ident_field high bit
    localparam int REV_LSB      = 5;  // revision low bit
    localparam int REV_MSB      = 6;  // revision high bit
    localparam int QSEL_BIT     = 0;  // input_quarter_rate select

    ////////////////////////////////////////////////////////////////////////////
    // writable-bit masks and reset values
    localparam logic [7:0] MASK_ALL      = 8'hFF;  // every bit writable
    localparam logic [7:0] MASK_NONE     = 8'h00;  // nothing writable
    localparam logic [7:0] MASK_MULT_HI  = 8'h3F;  // multiplier bits 13:8
    localparam logic [7:0] MASK_QSEL     = 8'h01;  // single select bit
    localparam logic [7:0] MASK_REF_IRQ  = 8'h01;  // one failure mask bit
    localparam logic [7:0] MASK_LOOP_IRQ = 8'h07;  // three loop mask bits
    localparam logic [7:0] REF_FAIL_RST  = 8'hFF;  // failure register at reset
    localparam logic [7:0] IRQ_MASK_RST  = 8'h00;  // interrupt masks at reset
    localparam logic [7:0] CFG_RST       = 8'h00;  // configuration at reset
    localparam logic [7:0] ZERO_BYTE     = 8'h00;  // unmapped read answer

    ////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_PERIOD_NS    = 10;    // mclk period
    localparam int RESET_SEQ_NS     = 1000;  // internal reset sequence length
    localparam int RESET_SEQ_CYCLES = (RESET_SEQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : rms_pkg

// File: core/rms_evt_if.sv
/*
 * rms_evt_if: carrier between the register bank and its sticky event unit.
 * assumes: both ends run on the same mclk.
 */
`timescale 1ns/10ps
interface rms_evt_if #(
    parameter int W = 3
);
    logic         ce;       // clock enable
    logic [W-1:0] set_ev;   // one-cycle event pulses
    logic         clr;      // read-clear strobe
    logic [W-1:0] mask;     // interrupt enables
    logic [W-1:0] status;   // sticky flags
    logic         pend;     // any enabled flag set

    modport owner (output ce, set_ev, clr, mask, input status, pend);
    modport flag  (input ce, set_ev, clr, mask, output status, pend);
endinterface : rms_evt_if

// File: core/rms_sticky.sv
/*
 * rms_sticky: sticky event flags cleared by a register read, with masked
 * pending output.
 * assumes: events and clear come from logic on mclk.
 */
`timescale 1ns/10ps
module rms_sticky #(
    parameter int W = 3
) (
    // clock and reset
    input  wire logic mclk,
    input  wire logic rstn,
    // carrier to the bank
    rms_evt_if.flag   ev
);

    logic [W-1:0] status_q;  // sticky flags

    ////////////////////////////////////////////////////////////////////////////
    // flags: set wins over a clear in the same cycle
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            status_q <= '0;
        end else if (ev.ce) begin
            // clear on read, then re-set any event of this cycle
            status_q <= (status_q & ~{W{ev.clr}}) | ev.set_ev;
        end
    end

    assign ev.status = status_q;
    // only enabled flags count toward the interrupt
    assign ev.pend   = |(status_q & ev.mask);

endmodule : rms_sticky

// File: core/rms_bank.sv
/*
 * rms_bank: register bank of the reference monitor: identity and
 * reset-ready, input failure status, sticky loop events, interrupt masks,
 * two custom monitoring profiles and the input prescaler control.
 * assumes: a serial port front end on mclk presents single-cycle read and
 * write strobes; monitor and loop logic deliver events on mclk.
 */
`timescale 1ns/10ps

// Overview of operation
// - lock event sets loop bit 0, read clears
// - lost-lock event sets loop bit 1, read clears
// - hold event sets loop bit 2, read clears
// - ready bit 7 rises after reset sequence
// - failure bit 0 follows failed reference
// - check cycles output is stored value plus one
// - select bit picks quarter-rate reference per profile
// - per-profile writable lower and upper cycle limits
// - frequency limits are low byte then high byte
// - profile B multiplier is fourteen bits split
// - read-write prescaler control register
// - fixed identity field and revision field
// - loop events interrupt only where mask is one
// - failure interrupts only where its mask is one
// - profile A multiplier is fourteen bits split
module rms_bank #(
    parameter logic [4:0] PART_IDENT = 5'h0A,  // arbitrary value
    parameter logic [1:0] REVISION   = 2'h1,   // arbitrary value
    parameter int         SEQ_CYCLES = rms_pkg::RESET_SEQ_CYCLES
) (
    // clock, reset, enable
    input  wire  logic        mclk,
    input  wire  logic        rstn,
    input  wire  logic        ce,
    // register port
    input  wire  logic [6:0]  reg_addr,
    input  wire  logic        reg_wr,
    input  wire  logic        reg_rd,
    input  wire  logic [7:0]  reg_wdata,
    output var   logic [7:0]  reg_rdata_q,
    output var   logic        reg_rvalid_q,
    // monitor and loop events
    input  wire  logic        lock_evt,
    input  wire  logic        lost_evt,
    input  wire  logic        hold_evt,
    input  wire  logic        ref_failed,
    // status
    output var   logic        irq_q,
    output var   logic        reset_ready_q,
    // profile A
    output var   logic [13:0] prof_a_mult_q,
    output var   logic [7:0]  prof_a_cyc_lower_q,
    output var   logic [7:0]  prof_a_cyc_upper_q,
    output var   logic [15:0] prof_a_freq_lower_q,
    output var   logic [15:0] prof_a_freq_upper_q,
    output var   logic [8:0]  prof_a_check_cycles_q,
    output var   logic        prof_a_input_quarter_rate_q,
    // profile B
    output var   logic [13:0] prof_b_mult_q,
    output var   logic [7:0]  prof_b_cyc_lower_q,
    output var   logic [7:0]  prof_b_cyc_upper_q,
    output var   logic [15:0] prof_b_freq_lower_q,
    output var   logic [15:0] prof_b_freq_upper_q,
    output var   logic [8:0]  prof_b_check_cycles_q,
    output var   logic        prof_b_input_quarter_rate_q,
    // prescaler
    output var   logic [7:0]  prescaler_q
);

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // writable bits of a configuration byte; reserved holes give none
    function automatic logic [7:0] cfg_mask(input logic [6:0] a);
        logic [7:0] m;
        m = rms_pkg::MASK_NONE;
        case (a)
            rms_pkg::OFF_A_MULT_HI,
            rms_pkg::OFF_B_MULT_HI:  m = rms_pkg::MASK_MULT_HI;
            rms_pkg::OFF_A_QSEL,
            rms_pkg::OFF_B_QSEL:     m = rms_pkg::MASK_QSEL;
            7'h7B, 7'h7C, 7'h7D:     m = rms_pkg::MASK_NONE;     // reserved hole
            default: begin
                // every other byte in range is fully writable
                if (a >= rms_pkg::CFG_FIRST && a <= rms_pkg::CFG_LAST) begin
                    m = rms_pkg::MASK_ALL;
                end
            end
        endcase
        return m;
    endfunction : cfg_mask

    // true when the address lies in configuration storage
    function automatic logic in_cfg(input logic [6:0] a);
        return (a >= rms_pkg::CFG_FIRST) && (a <= rms_pkg::CFG_LAST);
    endfunction : in_cfg

    // join a low byte and a high byte into a wider field
    function automatic logic [15:0] join16(input logic [7:0] lo, input logic [7:0] hi);
        return {hi, lo};
    endfunction : join16

    ////////////////////////////////////////////////////////////////////////////
    // storage

    localparam int CNT_W  = $clog2(SEQ_CYCLES + 1);  // reset sequence counter width
    localparam int MULT_W = rms_pkg::MULT_W;         // multiplier width, cuts the joined bytes

    logic [7:0]       cfg_mem [rms_pkg::CFG_FIRST:rms_pkg::CFG_LAST];  // profile and prescaler bytes
    logic [7:0]       ref_fail_q;        // input failure register
    logic [7:0]       ref_mask_q;        // failure interrupt mask
    logic [7:0]       loop_mask_q;       // loop event interrupt mask
    logic [CNT_W-1:0] seq_cnt_q;         // reset sequence counter
    logic             rd_loop;           // read of the loop event register
    logic [7:0]       ident_byte;        // assembled identity byte

    rms_evt_if #(.W(rms_pkg::LOOP_EVT_W)) loop_ev ();  // carrier to sticky flags

    ////////////////////////////////////////////////////////////////////////////
    // loop event flags

    assign rd_loop        = reg_rd && (reg_addr == rms_pkg::OFF_LOOP_EVT);
    assign loop_ev.ce     = ce;
    assign loop_ev.clr    = rd_loop;
    assign loop_ev.set_ev = {hold_evt, lost_evt, lock_evt};
    assign loop_ev.mask   = loop_mask_q[rms_pkg::LOOP_EVT_W-1:0];

    // sticky loop events with read-clear
    rms_sticky #(
        .W (rms_pkg::LOOP_EVT_W)
    ) u_loop_flags (
        .mclk (mclk),
        .rstn (rstn),
        .ev   (loop_ev)
    );

    ////////////////////////////////////////////////////////////////////////////
    // reset sequence: ready rises once the counter reaches its end
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            seq_cnt_q     <= '0;
            reset_ready_q <= 1'b0;
        end else if (ce) begin
            // count until the sequence is over, then hold ready
            if (seq_cnt_q == CNT_W'(SEQ_CYCLES)) begin
                reset_ready_q <= 1'b1;
            end else begin
                seq_cnt_q <= seq_cnt_q + 1'b1;
            end
        end
    end

    // identity byte: fixed fields plus the ready flag
    always_comb begin
        ident_byte = rms_pkg::ZERO_BYTE;
        ident_byte[rms_pkg::IDENT_MSB:rms_pkg::IDENT_LSB] = PART_IDENT;
        ident_byte[rms_pkg::REV_MSB:rms_pkg::REV_LSB]     = REVISION;
        ident_byte[rms_pkg::READY_BIT]                    = reset_ready_q;
    end

    ////////////////////////////////////////////////////////////////////////////
    // input failure register: bit 0 follows the failure judgement
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ref_fail_q <= rms_pkg::REF_FAIL_RST;
        end else if (ce) begin
            // reserved bits keep their reset ones
            ref_fail_q[rms_pkg::REF_FAIL_BIT] <= ref_failed;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt masks
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ref_mask_q  <= rms_pkg::IRQ_MASK_RST;
            loop_mask_q <= rms_pkg::IRQ_MASK_RST;
        end else if (ce && reg_wr) begin
            // only defined mask bits take a write
            if (reg_addr == rms_pkg::OFF_REF_MASK) begin
                ref_mask_q <= reg_wdata & rms_pkg::MASK_REF_IRQ;
            end
            if (reg_addr == rms_pkg::OFF_LOOP_MASK) begin
                loop_mask_q <= reg_wdata & rms_pkg::MASK_LOOP_IRQ;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration storage: masked byte writes
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            for (int i = rms_pkg::CFG_FIRST; i <= rms_pkg::CFG_LAST; i++) begin
                cfg_mem[i] <= rms_pkg::CFG_RST;
            end
        end else if (ce && reg_wr && in_cfg(reg_addr)) begin
            // reserved bits stay zero
            cfg_mem[reg_addr] <= reg_wdata & cfg_mask(reg_addr);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read port: data and valid one cycle after the strobe
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata_q  <= rms_pkg::ZERO_BYTE;
            reg_rvalid_q <= 1'b0;
        end else if (ce) begin
            reg_rvalid_q <= reg_rd;
            if (reg_rd) begin
                // decode the address; holes and unmapped read zero
                if (in_cfg(reg_addr)) begin
                    reg_rdata_q <= cfg_mem[reg_addr];
                end else begin
                    case (reg_addr)
                        rms_pkg::OFF_IDENT:     reg_rdata_q <= ident_byte;
                        rms_pkg::OFF_REF_FAIL:  reg_rdata_q <= ref_fail_q;
                        // value before the clear of this read
                        rms_pkg::OFF_LOOP_EVT:  reg_rdata_q <= {5'h00, loop_ev.status};
                        rms_pkg::OFF_REF_MASK:  reg_rdata_q <= ref_mask_q;
                        rms_pkg::OFF_LOOP_MASK: reg_rdata_q <= loop_mask_q;
                        default:                reg_rdata_q <= rms_pkg::ZERO_BYTE;
                    endcase
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt: any enabled status bit
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            irq_q <= 1'b0;
        end else if (ce) begin
            // loop flags gated inside the sticky unit, failure gated here
            irq_q <= loop_ev.pend
                   | (ref_fail_q[rms_pkg::REF_FAIL_BIT] & ref_mask_q[rms_pkg::REF_FAIL_BIT]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // profile A outputs, one cycle behind storage
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            prof_a_mult_q               <= '0;
            prof_a_cyc_lower_q          <= '0;
            prof_a_cyc_upper_q          <= '0;
            prof_a_freq_lower_q         <= '0;
            prof_a_freq_upper_q         <= '0;
            prof_a_check_cycles_q       <= '0;
            prof_a_input_quarter_rate_q <= 1'b0;
        end else if (ce) begin
            prof_a_mult_q <= MULT_W'(join16(cfg_mem[rms_pkg::OFF_A_MULT_LO],
                                            cfg_mem[rms_pkg::OFF_A_MULT_HI]));
            prof_a_cyc_lower_q  <= cfg_mem[rms_pkg::OFF_A_CYC_LOW];
            prof_a_cyc_upper_q  <= cfg_mem[rms_pkg::OFF_A_CYC_HIGH];
            prof_a_freq_lower_q <= join16(cfg_mem[rms_pkg::OFF_A_FLO_LO],
                                          cfg_mem[rms_pkg::OFF_A_FLO_HI]);
            prof_a_freq_upper_q <= join16(cfg_mem[rms_pkg::OFF_A_FHI_LO],
                                          cfg_mem[rms_pkg::OFF_A_FHI_HI]);
            // stored value k means k + 1 monitoring cycles
            prof_a_check_cycles_q <= {1'b0, cfg_mem[rms_pkg::OFF_A_CHECK]} + 9'h001;
            prof_a_input_quarter_rate_q <= cfg_mem[rms_pkg::OFF_A_QSEL][rms_pkg::QSEL_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // profile B outputs, one cycle behind storage
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            prof_b_mult_q               <= '0;
            prof_b_cyc_lower_q          <= '0;
            prof_b_cyc_upper_q          <= '0;
            prof_b_freq_lower_q         <= '0;
            prof_b_freq_upper_q         <= '0;
            prof_b_check_cycles_q       <= '0;
            prof_b_input_quarter_rate_q <= 1'b0;
        end else if (ce) begin
            prof_b_mult_q <= MULT_W'(join16(cfg_mem[rms_pkg::OFF_B_MULT_LO],
                                            cfg_mem[rms_pkg::OFF_B_MULT_HI]));
            prof_b_cyc_lower_q  <= cfg_mem[rms_pkg::OFF_B_CYC_LOW];
            prof_b_cyc_upper_q  <= cfg_mem[rms_pkg::OFF_B_CYC_HIGH];
            prof_b_freq_lower_q <= join16(cfg_mem[rms_pkg::OFF_B_FLO_LO],
                                          cfg_mem[rms_pkg::OFF_B_FLO_HI]);
            prof_b_freq_upper_q <= join16(cfg_mem[rms_pkg::OFF_B_FHI_LO],
                                          cfg_mem[rms_pkg::OFF_B_FHI_HI]);
            // stored value k means k + 1 monitoring cycles
            prof_b_check_cycles_q <= {1'b0, cfg_mem[rms_pkg::OFF_B_CHECK]} + 9'h001;
            prof_b_input_quarter_rate_q <= cfg_mem[rms_pkg::OFF_B_QSEL][rms_pkg::QSEL_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // prescaler output
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            prescaler_q <= rms_pkg::CFG_RST;
        end else if (ce) begin
            prescaler_q <= cfg_mem[rms_pkg::OFF_PRESCALE];
        end
    end

endmodule : rms_bank

// File: verification/rms_host.sv
/* rms_host: host model that issues register writes and reads to the bank.
   assumes: one-cycle strobes taken on mclk; read data stands until the next read. */
`timescale 1ns/10ps
module rms_host (
    // clock and answer
    input  wire logic       mclk,
    input  wire logic [7:0] reg_rdata_q,
    // request
    output var  logic [6:0] reg_addr,
    output var  logic       reg_wr,
    output var  logic       reg_rd,
    output var  logic [7:0] reg_wdata
);
    initial {reg_addr, reg_wr, reg_rd, reg_wdata} = '0;  // idle bus
    // one write strobe; afterwards the bus shows inverted values, not the old ones
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge mclk) #1 {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
        @(posedge mclk) #1 {reg_addr, reg_wdata, reg_wr} = {~a, ~d, 1'b0};
    endtask : wr
    // one read strobe; data taken at the edge after the answer
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(posedge mclk) #1 {reg_addr, reg_rd} = {a, 1'b1};
        @(posedge mclk) #1 {reg_addr, reg_rd} = {~a, 1'b0};
        @(posedge mclk) d = reg_rdata_q;
    endtask : rd
endmodule : rms_host

// File: verification/rms_bank_chk.sv
/* rms_bank_chk: port-level checks of the register bank.
   assumes: bound to rms_bank, one mclk domain. */
`timescale 1ns/10ps
module rms_bank_chk #(
    parameter logic [4:0] PART_IDENT = 5'h0A,
    parameter logic [1:0] REVISION   = 2'h1
) (
    input wire logic       mclk, rstn, ce, reg_wr, reg_rd, lock_evt, lost_evt, hold_evt, ref_failed, reset_ready_q,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_wdata, reg_rdata_q,
    input wire logic [8:0] prof_a_check_cycles_q
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    wire quiet = ce && !lock_evt && !lost_evt && !hold_evt;  // no loop event this cycle
    wire rdl   = ce && reg_rd && reg_addr == 7'h03;           // read of the loop event register
    a_lock_sets_bit: assert property (ce && lock_evt ##1 !rdl ##1 rdl |=> reg_rdata_q[0])
        else $error("lock flag missing");
    a_lost_sets_bit: assert property (ce && lost_evt ##1 !rdl ##1 rdl |=> reg_rdata_q[1])
        else $error("lost lock flag missing");
    a_hold_sets_bit: assert property (ce && hold_evt ##1 !rdl ##1 rdl |=> reg_rdata_q[2])
        else $error("hold flag missing");
    a_read_clears_flags: assert property (rdl && quiet ##1 (quiet && !reg_rd)[*2] ##1 rdl |=>
        reg_rdata_q[2:0] == 3'h0) else $error("loop flags not cleared by read");
    a_ready_stays_set: assert property (reset_ready_q |=> reset_ready_q)
        else $error("ready bit fell");
    a_ident_field_fixed: assert property (ce && reg_rd && reg_addr == 7'h00 |=>
        reg_rdata_q[6:0] == {REVISION, PART_IDENT}) else $error("identity field wrong");
    a_fail_bit_follows: assert property (ce ##1 ce && reg_rd && reg_addr == 7'h02 && ref_failed == $past(ref_failed)
        |=> reg_rdata_q == {7'h7F, $past(ref_failed)}) else $error("failure register wrong");
    a_check_plus_one: assert property (ce && reg_wr && reg_addr == 7'h6F ##1 ce |=>
        prof_a_check_cycles_q == {1'b0, $past(reg_wdata, 2)} + 9'h001) else $error("check cycles wrong");
endmodule : rms_bank_chk
bind rms_bank rms_bank_chk #(.PART_IDENT(PART_IDENT), .REVISION(REVISION)) u_chk (
    .mclk(mclk), .rstn(rstn), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd), .lock_evt(lock_evt), .lost_evt(lost_evt),
    .hold_evt(hold_evt), .ref_failed(ref_failed), .reset_ready_q(reset_ready_q), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .prof_a_check_cycles_q(prof_a_check_cycles_q));

// File: verification/rms_bank_tb.sv
/* rms_bank_tb: directed register tests of the bank through the host model.
   assumes: rms_host tasks wr and rd; checker bound to the bank. */
`timescale 1ns/10ps
module rms_bank_tb;
    localparam logic [4:0] IDENT = 5'h15;  // arbitrary value
    localparam logic [1:0] REV   = 2'h2;   // arbitrary value
    logic        mclk = 1'b0, rstn = 1'b0, ce = 1'b1, ref_failed = 1'b0;
    logic [2:0]  evt  = 3'h0;  // hold, lost, lock pulses
    logic [6:0]  reg_addr;
    logic        reg_wr, reg_rd, reg_rvalid_q, irq_q, ready_q, qa, qb;
    logic [7:0]  reg_wdata, reg_rdata_q, prescaler_q, d, cyl_b, cyu_b, cyl_a, cyu_a;
    logic [13:0] mult_a, mult_b;
    logic [15:0] flo_a, fhi_a, flo_b, fhi_b;
    logic [8:0]  chk_a, chk_b;
    int          bad_count = 0, comparisons = 0, cyc = 0;
    always #5 mclk = ~mclk;
    rms_bank #(.PART_IDENT(IDENT), .REVISION(REV), .SEQ_CYCLES(4)) dut (
        .mclk(mclk), .rstn(rstn), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q), .lock_evt(evt[0]),
        .lost_evt(evt[1]), .hold_evt(evt[2]), .ref_failed(ref_failed), .irq_q(irq_q), .reset_ready_q(ready_q),
        .prof_a_mult_q(mult_a), .prof_a_cyc_lower_q(cyl_a), .prof_a_cyc_upper_q(cyu_a), .prof_a_freq_lower_q(flo_a),
        .prof_a_freq_upper_q(fhi_a), .prof_a_check_cycles_q(chk_a), .prof_a_input_quarter_rate_q(qa),
        .prof_b_mult_q(mult_b), .prof_b_cyc_lower_q(cyl_b), .prof_b_cyc_upper_q(cyu_b), .prof_b_freq_lower_q(flo_b),
        .prof_b_freq_upper_q(fhi_b), .prof_b_check_cycles_q(chk_b), .prof_b_input_quarter_rate_q(qb),
        .prescaler_q(prescaler_q));
    rms_host host (.mclk(mclk), .reg_rdata_q(reg_rdata_q), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata));
    // compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rdc(input logic [6:0] a, input logic [7:0] exp);
        host.rd(a, d);
        chk({7'h00, reg_rvalid_q, d}, {7'h00, 1'b1, exp});
    endtask : rdc
    task automatic pulse(input logic [2:0] e);
        @(posedge mclk) #1 evt = e;
        @(posedge mclk) #1 evt = 3'h0;
    endtask : pulse
    task automatic irqc(input logic exp);
        repeat (2) @(posedge mclk);
        #1 chk({14'h0000, irq_q, reg_rvalid_q}, {14'h0000, exp, 1'b0});
    endtask : irqc
    // bits that take a write, per address
    function automatic logic [7:0] wmask(input logic [6:0] a);
        if (a == 7'h68 || a == 7'h72) return 8'h3F;
        if (a == 7'h70 || a == 7'h7A) return 8'h01;
        if (a > 7'h7A && a < 7'h7E) return 8'h00;
        return 8'hFF;
    endfunction : wmask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : give_verdict
    // hang guard
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            $display("[ERR] %0t timeout", $time);
            give_verdict();
        end
    end
    initial begin
        repeat (8) @(posedge mclk);
        #1 rstn = 1'b1;
        rdc(7'h00, {1'b0, REV, IDENT});
        repeat (10) @(posedge mclk);
        host.wr(7'h00, 8'h00);
        rdc(7'h00, {1'b1, REV, IDENT});
        rdc(7'h02, 8'hFE);
        #1 ref_failed = 1'b1;
        rdc(7'h02, 8'hFF);
        for (int i = 0; i < 3; i++) begin
            pulse(3'h1 << i);
            rdc(7'h03, 8'h01 << i);
            rdc(7'h03, 8'h00);
        end
        host.wr(7'h0A, 8'h01);
        pulse(3'h2);
        irqc(1'b0);
        pulse(3'h1);
        irqc(1'b1);
        rdc(7'h03, 8'h03);
        irqc(1'b0);
        host.wr(7'h09, 8'h01);
        irqc(1'b1);
        host.wr(7'h09, 8'h00);
        irqc(1'b0);
        for (int a = 'h67; a <= 'h7E; a++) host.wr(7'(a), {7'(a), 1'b1});
        for (int a = 'h67; a <= 'h7E; a++) rdc(7'(a), {7'(a), 1'b1} & wmask(7'(a)));
        rdc(7'h7F, 8'h00);
        chk({2'b00, mult_a}, 16'h11CF);
        chk({7'h00, chk_a}, 16'h00E0);
        chk(flo_a, 16'hD9D7);
        chk({14'h0000, qa, qb}, 16'h0003);
        chk({2'b00, mult_b}, 16'h25E3);
        chk({cyl_b, cyu_b}, 16'hE7E9);
        chk({8'h00, prescaler_q}, 16'h00FD);
        chk({cyl_a, cyu_a}, 16'hD3D5);
        chk(fhi_a, 16'hDDDB);
        chk(flo_b, 16'hEDEB);
        chk(fhi_b, 16'hF1EF);
        chk({7'h00, chk_b}, 16'h00F4);
        #1 ce = 1'b0;
        host.wr(7'h7E, 8'h00);
        ce = 1'b1;
        rdc(7'h7E, 8'hFD);
        give_verdict();
    end
endmodule : rms_bank_tb
